// ===== rtl/uesc_pkg.sv
// Package of the endpoint status and control block: register map,
// field positions, reset values, token and answer codes, carriers.
// Assumes a 32-bit AHB-Lite register bus and a byte-wide engine side.
package uesc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int STAT_DEPTH = 4;
    localparam int EP_COUNT = 16;

    // ------------------------------------------------------------
    // Address map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [31:0] RAM_LO = 32'h0000_0060;
    localparam logic [31:0] RAM_HI = 32'h0000_0F3F;
    localparam logic [31:0] BD_LO = 32'h0000_0400;
    localparam logic [31:0] BD_HI = 32'h0000_04FF;
    localparam int RAM_BYTES = 32'(RAM_HI - RAM_LO) + 1;
    localparam logic [31:0] OFS_STATUS = 32'h0000_1000;
    localparam logic [31:0] OFS_ADDR = 32'h0000_1004;
    localparam logic [31:0] OFS_FRML = 32'h0000_1008;
    localparam logic [31:0] OFS_FRMH = 32'h0000_100C;
    localparam logic [31:0] OFS_CTRL = 32'h0000_1010;
    localparam logic [31:0] OFS_EP_BASE = 32'h0000_1040;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int EP_HS_BIT = 4;
    localparam int EP_CD_BIT = 3;
    localparam int EP_OUT_BIT = 2;
    localparam int EP_IN_BIT = 1;
    localparam int EP_STALL_BIT = 0;
    localparam int CTRL_TRN_BIT = 0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [4:0] EP_RESET = 5'h00;

    // ------------------------------------------------------------
    // Codes and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TOK_OUT = 2'b00,
        TOK_IN = 2'b01,
        TOK_SETUP = 2'b10,
        TOK_SOF = 2'b11
    } uesc_tok_e;

    typedef enum logic [1:0] {
        RSP_NONE = 2'b00,
        RSP_ACK = 2'b01,
        RSP_NAK = 2'b10,
        RSP_STALL = 2'b11
    } uesc_rsp_e;

    typedef struct packed {
        logic valid;
        uesc_tok_e kind;
        logic [6:0] addr;
        logic [3:0] endp;
        logic [10:0] frame;
    } uesc_tok_s;

    typedef struct packed {
        logic valid;
        logic [3:0] endp;
        logic dir;
        logic odd;
    } uesc_done_s;

    typedef struct packed {
        logic valid;
        logic [3:0] endp;
    } uesc_stall_s;

    typedef struct packed {
        uesc_rsp_e code;
        logic handshake;
    } uesc_resp_s;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } uesc_ram_s;

endpackage : uesc_pkg

// ===== rtl/uesc_top.sv
// Endpoint control, transfer status FIFO, bus address, frame number
// and dual-access USB RAM of a full/low-speed serial engine.
// Assumes AHB-Lite single word transfers and an engine that gives
// decoded tokens, completion and stall events synchronous to hclk.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns

module uesc_top #(
    parameter int STAT_DEPTH_P = uesc_pkg::STAT_DEPTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Engine events
    input wire uesc_pkg::uesc_tok_s tok,
    input wire uesc_pkg::uesc_done_s done,
    input wire uesc_pkg::uesc_stall_s stall_evt,
    input wire logic bus_reset_flag,
    input wire logic suspend_bit,
    // Engine answers
    output uesc_pkg::uesc_resp_s resp,
    output logic transfer_complete_flag,
    // Engine RAM port
    input wire uesc_pkg::uesc_ram_s eng_ram,
    output logic [7:0] eng_ram_rdata,
    output logic eng_ram_bd
);
    import uesc_pkg::*;

    localparam int PW = $clog2(STAT_DEPTH_P);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_span(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_span

    function automatic logic [11:0] ram_idx(input logic [31:0] a);
        logic [31:0] d;
        d = a - RAM_LO;
        return d[11:0];
    endfunction : ram_idx

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic a_valid;
    logic a_write;
    logic [31:0] a_addr;
    logic [7:0] dev_addr;
    logic [10:0] frame;
    logic [4:0] ep_ctrl [EP_COUNT];
    logic [7:0] stat_q [STAT_DEPTH_P];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic [7:0] ram_mem [RAM_BYTES];

    // ------------------------------------------------------------
    // Bus address phase and write decode
    // ------------------------------------------------------------
    wire take = hsel & hready & htrans[1];
    wire rd_take = take & ~hwrite;
    wire wr_en = a_valid & a_write;
    wire wr_ram = wr_en & in_span(a_addr, RAM_LO, RAM_HI);
    wire wr_ep = wr_en & (a_addr[31:6] == OFS_EP_BASE[31:6]);
    wire wr_addr = wr_en & (a_addr == OFS_ADDR);
    wire clr = wr_en & (a_addr == OFS_CTRL) & hwdata[CTRL_TRN_BIT];
    wire [11:0] wi = ram_idx(a_addr);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_addr <= 32'h0000_0000;
        end else if (hready) begin
            a_valid <= take;
            a_write <= hwrite;
            a_addr <= haddr;
        end
    end

    // ------------------------------------------------------------
    // Status FIFO
    // ------------------------------------------------------------
    wire full = (cnt == (PW+1)'(STAT_DEPTH_P));
    wire push = done.valid & ~full;
    wire pop = clr & transfer_complete_flag;
    wire [7:0] push_byte = {1'b0, done.endp, done.dir, done.odd, 1'b0};
    wire [7:0] status_head = stat_q[rp];

    // Pointer and count; a bus reset empties the queue
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else if (bus_reset_flag) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= pop ? rp + 1'b1 : rp;
            cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Entry storage: endpoint, direction and bank
    always_ff @(posedge hclk) begin
        if (push) begin
            stat_q[wp] <= push_byte;
        end
    end

    // Flag drops for one cycle on clear, returns while entries wait;
    // an event in the clear cycle is queued unless the queue is full, and raises it again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_complete_flag <= 1'b0;
        end else if (bus_reset_flag || clr) begin
            transfer_complete_flag <= 1'b0;
        end else if (cnt != '0) begin
            transfer_complete_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Address and frame registers
    // ------------------------------------------------------------
    // Bus reset wins over a firmware write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_addr <= ADDR_RESET;
        end else if (bus_reset_flag) begin
            dev_addr <= ADDR_RESET;
        end else if (wr_addr) begin
            dev_addr <= hwdata[7:0];
        end
    end

    // Frame number loads on SOF; bus writes have no path here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame <= 11'h000;
        end else if (tok.valid && tok.kind == TOK_SOF) begin
            frame <= tok.frame;
        end
    end

    // ------------------------------------------------------------
    // Endpoint control registers
    // ------------------------------------------------------------
    // Stall event from the engine wins over a firmware write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int n = 0; n < EP_COUNT; n++) begin
                ep_ctrl[n] <= EP_RESET;
            end
        end else begin
            for (int n = 0; n < EP_COUNT; n++) begin
                if (wr_ep && a_addr[5:2] == 4'(n)) begin
                    ep_ctrl[n] <= hwdata[4:0];
                end
                if (stall_evt.valid && stall_evt.endp == 4'(n)) begin
                    ep_ctrl[n][EP_STALL_BIT] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Token answer
    // ------------------------------------------------------------
    wire [4:0] tep = ep_ctrl[tok.endp];
    wire t_en = tep[EP_OUT_BIT] | tep[EP_IN_BIT];
    wire t_addr_ok = (tok.addr == dev_addr[6:0]);
    wire t_both = tep[EP_OUT_BIT] & tep[EP_IN_BIT];
    wire t_dir_ok = (tok.kind == TOK_OUT) ? tep[EP_OUT_BIT] :
                    (tok.kind == TOK_IN) ? tep[EP_IN_BIT] :
                    (tok.kind == TOK_SETUP) ? t_both & ~tep[EP_CD_BIT] :
                    1'b0;
    wire t_req = tok.valid & (tok.kind != TOK_SOF) & t_addr_ok & t_dir_ok;
    wire t_stall = t_en & tep[EP_STALL_BIT];
    wire uesc_rsp_e next_code = !t_req ? RSP_NONE :
                                t_stall ? RSP_STALL :
                                full ? RSP_NAK : RSP_ACK;

    // Answer one cycle after the token
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp <= '{code: RSP_NONE, handshake: 1'b0};
        end else begin
            resp <= '{code: next_code,
                      handshake: t_req & tep[EP_HS_BIT]};
        end
    end

    // ------------------------------------------------------------
    // USB RAM, shared by bus and engine
    // ------------------------------------------------------------
    wire [31:0] e_addr = {20'h00000, eng_ram.addr};
    wire e_in = in_span(e_addr, RAM_LO, RAM_HI);
    wire [11:0] ei = ram_idx(e_addr);

    // Engine write wins on the same byte; ownership is left to
    // firmware, no lockout is applied
    always_ff @(posedge hclk) begin
        if (wr_ram) begin
            ram_mem[wi] <= hwdata[7:0];
            ram_mem[wi + 12'h001] <= hwdata[15:8];
            ram_mem[wi + 12'h002] <= hwdata[23:16];
            ram_mem[wi + 12'h003] <= hwdata[31:24];
        end
        if (eng_ram.we && e_in) begin
            ram_mem[ei] <= eng_ram.wdata;
        end
    end

    // Engine read data and descriptor-space marker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_ram_rdata <= 8'h00;
            eng_ram_bd <= 1'b0;
        end else begin
            eng_ram_rdata <= e_in ? ram_mem[ei] : 8'h00;
            eng_ram_bd <= in_span(e_addr, BD_LO, BD_HI);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire rd_ram = in_span(haddr, RAM_LO, RAM_HI);
    wire rd_ep = (haddr[31:6] == OFS_EP_BASE[31:6]);
    wire [11:0] ri = ram_idx(haddr);
    wire [31:0] ram_word = {ram_mem[ri + 12'h003], ram_mem[ri + 12'h002],
                            ram_mem[ri + 12'h001], ram_mem[ri]};
    wire [7:0] ctrl_rd = {5'h00, bus_reset_flag, suspend_bit,
                          transfer_complete_flag};
    wire [7:0] reg_byte = (haddr == OFS_STATUS) ? status_head :
                          (haddr == OFS_ADDR) ? dev_addr :
                          (haddr == OFS_FRML) ? frame[7:0] :
                          (haddr == OFS_FRMH) ? {5'h00, frame[10:8]} :
                          (haddr == OFS_CTRL) ? ctrl_rd :
                          rd_ep ? {3'h0, ep_ctrl[haddr[5:2]]} :
                          8'h00;
    wire [31:0] rd_word = rd_ram ? ram_word : {24'h000000, reg_byte};

    // Read data captured at the address phase, held until next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_status_load;
        done.valid && cnt == '0 && !bus_reset_flag
            |=> status_head == $past(push_byte);
    endproperty
    a_status_load: assert property (p_status_load)
        else $error("status head does not hold the completed transfer");

    property p_ep_upper_zero;
        rd_take && rd_ep |=> hrdata == {27'h0, $past(ep_ctrl[haddr[5:2]])};
    endproperty
    a_ep_upper_zero: assert property (p_ep_upper_zero)
        else $error("endpoint control upper bits not zero");

    property p_no_handshake;
        tok.valid && !tep[EP_HS_BIT] |=> !resp.handshake;
    endproperty
    a_no_handshake: assert property (p_no_handshake)
        else $error("handshake given while disabled");

    property p_setup_refused;
        tok.valid && tok.kind == TOK_SETUP && tep[EP_CD_BIT]
            |=> resp.code == RSP_NONE;
    endproperty
    a_setup_refused: assert property (p_setup_refused)
        else $error("SETUP answered on control-disabled endpoint");

    property p_out_gate;
        tok.valid && tok.kind == TOK_OUT && !tep[EP_OUT_BIT]
            |=> resp.code == RSP_NONE;
    endproperty
    a_out_gate: assert property (p_out_gate)
        else $error("OUT answered while output disabled");

    property p_stall_set;
        stall_evt.valid |=> ep_ctrl[$past(stall_evt.endp)][EP_STALL_BIT];
    endproperty
    a_stall_set: assert property (p_stall_set)
        else $error("stall bit not set after stall event");

    property p_addr_clear;
        bus_reset_flag |=> dev_addr == ADDR_RESET ##1 dev_addr == ADDR_RESET
            || $past(wr_addr);
    endproperty
    a_addr_clear: assert property (p_addr_clear)
        else $error("bus address not cleared by bus reset");

    property p_sof_load;
        tok.valid && tok.kind == TOK_SOF |=> frame == $past(tok.frame);
    endproperty
    a_sof_load: assert property (p_sof_load)
        else $error("frame number not loaded from SOF");

    property p_reassert;
        disable iff (!hresetn || bus_reset_flag)
        pop && cnt > (PW+1)'(1) ##1 !clr[*2] |-> ##[0:4] transfer_complete_flag;
    endproperty
    a_reassert: assert property (p_reassert)
        else $error("complete flag not raised again for queued entry");

    property p_full_nak;
        t_req && !t_stall && full |=> resp.code == RSP_NAK;
    endproperty
    a_full_nak: assert property (p_full_nak)
        else $error("request on full status queue not NAKed");

    property p_addr_match;
        tok.valid && tok.kind != TOK_SOF && !t_addr_ok
            |=> resp.code == RSP_NONE && !resp.handshake;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("token for another address was answered");

endmodule : uesc_top

// ===== dv/uesc_host_model.sv
// Host-side token source for the endpoint status and control block.
// Assumes the bench asks for at most one token per clock cycle.
`timescale 1ns/1ns

module uesc_host_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Token request from the bench, token towards the block
    input wire uesc_pkg::uesc_tok_s req,
    output uesc_pkg::uesc_tok_s tok
);
    import uesc_pkg::*;

    // Idle cycles carry scrambled fields so stale tokens never pass
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tok <= '0;
        end else if (req.valid) begin
            tok <= req;
        end else begin
            tok <= {1'b0, ~tok[$bits(tok)-2:0]};
        end
    end
endmodule : uesc_host_model

// ===== dv/testbench.sv
// Self-checking bench of the endpoint status and control block.
// Assumes the host model turns bench requests into tokens.
`timescale 1ns/1ns

module testbench;
    import uesc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, obs, w0, w4;
    uesc_tok_s req, tok;
    uesc_done_s done;
    uesc_stall_s stall_evt;
    uesc_resp_s resp;
    uesc_ram_s eng_ram;
    logic bus_reset_flag, suspend_bit, flag, eng_ram_bd;
    logic [7:0] eng_ram_rdata;
    logic [6:0] dev;
    logic [10:0] frm;
    logic [7:0] st [4];
    logic [12:0] tbl [11];
    logic [31:0] exp_q [$], tag_q [$];
    uesc_resp_s rsp_q [$];
    logic obs_v = 1'b0;
    logic ans_due = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;

    uesc_top #(.STAT_DEPTH_P(STAT_DEPTH)) uesc_top_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tok(tok), .done(done), .stall_evt(stall_evt),
        .bus_reset_flag(bus_reset_flag), .suspend_bit(suspend_bit),
        .resp(resp), .transfer_complete_flag(flag), .eng_ram(eng_ram),
        .eng_ram_rdata(eng_ram_rdata), .eng_ram_bd(eng_ram_bd));
    uesc_host_model uesc_host_model_i (.hclk(hclk), .hresetn(hresetn),
        .req(req), .tok(tok));

    // Clock of 10 ns
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic cmp_word(input logic [31:0] name, input logic [31:0] e,
                            input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] word %h expected %h seen %h", name, e, g);
        end
    endtask : cmp_word

    task automatic cmp_resp(input uesc_resp_s e, input uesc_resp_s g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] token answer expected %h seen %h", e, g);
        end
    endtask : cmp_resp

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Takes the oldest note whenever a result shows up
    always @(posedge hclk) begin
        if (obs_v) begin
            cmp_word(tag_q.pop_front(), exp_q.pop_front(), obs);
            obs_v <= 1'b0;
        end
        if (ans_due) begin
            cmp_resp(rsp_q.pop_front(), resp);
        end
        ans_due <= tok.valid;
    end

    // Cuts a hang short
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        tag_q.push_back(a);
        exp_q.push_back(e);
        obs <= q;
        obs_v <= 1'b1;
    endtask : rd

    task automatic er(input logic [11:0] a, input logic [31:0] e);
        eng_ram <= '{1'b0, a, 8'h00};
        repeat (2) @(posedge hclk);
        tag_q.push_back({20'h0, a});
        exp_q.push_back(e);
        obs <= {23'h0, eng_ram_bd, eng_ram_rdata};
        obs_v <= 1'b1;
    endtask : er

    // Notes a level seen on a pin; waits two edges, the first for the watcher
    task automatic pin(input logic [31:0] a, input logic [31:0] e,
                       input logic [31:0] g);
        tag_q.push_back(a);
        exp_q.push_back(e);
        obs <= g;
        obs_v <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : pin

    task automatic tk(input uesc_tok_e k, input logic [3:0] e,
                      input logic [6:0] a, input uesc_rsp_e c,
                      input logic h);
        rsp_q.push_back('{c, h});
        req <= '{1'b1, k, a, e, frm};
        @(posedge hclk);
        req.valid <= 1'b0;
        @(posedge hclk);
    endtask : tk

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int e;
        logic [31:0] w;
        {hsel, hwrite, hresetn, bus_reset_flag, suspend_bit} = '0;
        {htrans, haddr, hwdata, req, done, stall_evt, eng_ram} = '0;
        frm = 11'h0;
        tbl = '{{8'h16, TOK_OUT, RSP_ACK, 1'b1},
            {8'h16, TOK_IN, RSP_ACK, 1'b1}, {8'h16, TOK_SETUP, RSP_ACK, 1'b1},
            {8'h1E, TOK_SETUP, RSP_NONE, 1'b0}, {8'h1E, TOK_IN, RSP_ACK, 1'b1},
            {8'h04, TOK_OUT, RSP_ACK, 1'b0}, {8'h04, TOK_IN, RSP_NONE, 1'b0},
            {8'h06, TOK_SETUP, RSP_ACK, 1'b0},
            {8'h12, TOK_OUT, RSP_NONE, 1'b0},
            {8'h13, TOK_IN, RSP_STALL, 1'b1},
            {8'h11, TOK_IN, RSP_NONE, 1'b0}};
        void'($urandom(32'h5393));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_ADDR, 32'h0);
        rd(OFS_FRMH, 32'h0);
        rd(OFS_CTRL, 32'h0);
        for (e = 0; e < 16; e++) begin
            w = $urandom;
            if (e == 0) w[EP_CD_BIT] = 1'b0;
            rd(OFS_EP_BASE + 32'(4 * e), 32'h0);
            wr(OFS_EP_BASE + 32'(4 * e), w);
            rd(OFS_EP_BASE + 32'(4 * e), {27'h0, w[4:0]});
        end
        dev = 7'($urandom_range(1, 127));
        wr(OFS_ADDR, {25'h0, dev});
        pin(32'h0, 32'h1, {30'h0, hresp, hreadyout});
        rd(OFS_ADDR, {25'h0, dev});
        for (e = 0; e < 11; e++) begin
            wr(OFS_EP_BASE + 32'(4 * (e + 1)), {24'h0, tbl[e][12:5]});
            tk(uesc_tok_e'(tbl[e][4:3]), 4'(e + 1), dev,
               uesc_rsp_e'(tbl[e][2:1]), tbl[e][0]);
        end
        tk(TOK_OUT, 4'd1, dev ^ 7'h01, RSP_NONE, 1'b0);
        stall_evt <= '{1'b1, 4'd2};
        @(posedge hclk);
        stall_evt <= '0;
        rd(OFS_EP_BASE + 32'h8, 32'h17);
        tk(TOK_IN, 4'd2, dev, RSP_STALL, 1'b1);
        wr(OFS_EP_BASE + 32'h8, 32'h16);
        rd(OFS_EP_BASE + 32'h8, 32'h16);
        frm = 11'($urandom);
        tk(TOK_SOF, 4'd0, dev, RSP_NONE, 1'b0);
        wr(OFS_FRML, 32'hFF);
        rd(OFS_FRML, {24'h0, frm[7:0]});
        rd(OFS_FRMH, {29'h0, frm[10:8]});
        for (e = 0; e < 5; e++) begin
            w = $urandom;
            if (e < 4) st[e] = {1'b0, w[3:0], w[4], w[5], 1'b0};
            done <= '{1'b1, w[3:0], w[4], w[5]};
            @(posedge hclk);
        end
        done <= '0;
        tk(TOK_OUT, 4'd1, dev, RSP_NAK, 1'b1);
        rd(OFS_CTRL, 32'h1);
        for (e = 0; e < 4; e++) begin
            rd(OFS_STATUS, {24'h0, st[e]});
            wr(OFS_CTRL, 32'h1);
            repeat (2) @(posedge hclk);
            pin(OFS_CTRL, 32'(e < 3), {31'h0, flag});
            rd(OFS_CTRL, 32'(e < 3));
        end
        tk(TOK_OUT, 4'd1, dev, RSP_ACK, 1'b1);
        suspend_bit <= 1'b1;
        @(posedge hclk);
        rd(OFS_CTRL, 32'h2);
        suspend_bit <= 1'b0;
        bus_reset_flag <= 1'b1;
        @(posedge hclk);
        bus_reset_flag <= 1'b0;
        rd(OFS_ADDR, 32'h0);
        tk(TOK_OUT, 4'd1, dev, RSP_NONE, 1'b0);
        tk(TOK_OUT, 4'd1, 7'h00, RSP_ACK, 1'b1);
        w0 = $urandom;
        w4 = $urandom;
        wr(RAM_LO, w0);
        wr(BD_LO, w4);
        wr(32'h0F40, 32'hFFFF_FFFF);
        rd(32'h0F40, 32'h0);
        er(12'h061, {23'h0, 1'b0, w0[15:8]});
        er(12'h402, {23'h0, 1'b1, w4[23:16]});
        eng_ram <= '{1'b1, 12'h062, 8'hA5};
        @(posedge hclk);
        eng_ram <= '0;
        rd(RAM_LO, {w0[31:24], 8'hA5, w0[15:0]});
        rd(BD_LO, w4);
        wr(32'h0F3C, w0);
        rd(32'h0F3C, w0);
        repeat (4) @(posedge hclk);
        results();
    end
endmodule : testbench
